/* hw/oel_cfg.svh */
`ifndef OEL_CFG_SVH
`define OEL_CFG_SVH

// register offsets on the register interface
`define OEL_ADDR_W          6
`define OEL_ADDR_FALL_EN    6'h10
`define OEL_ADDR_FALL_SET   6'h11
`define OEL_ADDR_FALL_CLR   6'h12
`define OEL_ADDR_STATUS     6'h13
`define OEL_ADDR_LATCH      6'h14

// field layout of the latch, status and enable registers
`define OEL_DATA_W          8
`define OEL_SRC_W           5
`define OEL_BIT_ID_GND      4
`define OEL_BIT_SESS_END    3
`define OEL_BIT_SESS_VALID  2
`define OEL_BIT_VBUS_OK     1
`define OEL_BIT_HOST_DETACH 0

// reset values
`define OEL_FALL_EN_RST     5'h1F
`define OEL_LATCH_RST       5'h00
`define OEL_RDATA_RST       8'h00

`endif

/* hw/oel_pkg.sv */
`include "oel_cfg.svh"

package oel_pkg;

  // the five cable and session sources, msb first so bit 4 is id grounded
  typedef struct packed {
    logic id_pin_grounded;
    logic session_ended;
    logic session_is_valid;
    logic bus_voltage_ok;
    logic host_detach;
  } oel_src_t;

  // operating modes whose entry wipes the latch
  typedef struct packed {
    logic low_power;
    logic serial;
    logic carkit;
  } oel_mode_t;

  // register access request from the interface logic
  typedef struct packed {
    logic                        rd;
    logic                        wr;
    logic [`OEL_ADDR_W-1:0]      addr;
    logic [`OEL_DATA_W-1:0]      wdata;
  } oel_req_t;

  // start-up walk: gray codes along the path
  typedef enum logic [1:0] {
    OEL_ST_SYNC0 = 2'b00,
    OEL_ST_SYNC1 = 2'b01,
    OEL_ST_LOAD  = 2'b11,
    OEL_ST_RUN   = 2'b10
  } oel_state_t;

endpackage

/* hw/oel_src_track.sv */
`timescale 1ns/100ps
`default_nettype none

// synchronises the analog source levels and flags their transitions
module oel_src_track #(
  parameter int W = 5
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] src_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_src
      // meta_ff feeds only sync_ff
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
          prev_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= src_i[g];
          sync_ff[g] <= meta_ff[g];
          prev_ff[g] <= sync_ff[g];
        end
      end
      assign rise_o[g] = sync_ff[g] & ~prev_ff[g];
      assign fall_o[g] = ~sync_ff[g] & prev_ff[g];
    end
  endgenerate

  assign level_o = sync_ff;

endmodule

`default_nettype wire

/* hw/oel_latch.sv */
`timescale 1ns/100ps
`default_nettype none
`include "oel_cfg.svh"

// What this block does
// - A latch bit goes to one when its source shows a change that is not masked.
// - Latch bits are id grounded 4, session end 3, session valid 2, bus voltage 1, detach 0.
// - A read of the latch register at 0x14 returns its contents and then clears every bit.
// - Entering low power clears all latch bits except one whose event lands in the entry cycle.
// - Entering serial or carkit mode clears all latch bits except a same-cycle event, regardless of clock suspend.
// - An event in the cycle of a latch read is reported in that read data and not latched.
// - The host detach event counts only while the device is in host mode.
// - After reset the detach bit is zero with a host attached and one with it detached.
// - A read-only status register at 0x13 shows the present level of the five sources.
// - Fall enables: plain 0x10, set 0x11, clear 0x12; at set and clear a zero bit changes nothing.
module oel_latch (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire oel_pkg::oel_req_t      req_i,
  input  wire oel_pkg::oel_src_t      src_i,
  input  wire logic [`OEL_SRC_W-1:0]  rise_en_i,
  input  wire logic                   host_mode_i,
  input  wire oel_pkg::oel_mode_t     mode_i,
  output logic [`OEL_DATA_W-1:0]      rd_data_o,
  output logic                        rd_valid_o,
  output logic                        rd_hit_o,
  output logic [`OEL_SRC_W-1:0]       latch_o,
  output logic [`OEL_SRC_W-1:0]       fall_en_o
);

  // alias write: 0 = plain write, 1 = set ones, 2 = clear ones
  function automatic logic [`OEL_SRC_W-1:0] alias_write(
    input logic [`OEL_SRC_W-1:0] cur,
    input logic [`OEL_SRC_W-1:0] wval,
    input logic [1:0]            op
  );
    logic [`OEL_SRC_W-1:0] res;
    res = cur;
    unique case (op)
      2'd0: res = wval;
      2'd1: res = cur | wval;
      2'd2: res = cur & ~wval;
      default: res = cur;
    endcase
    return res;
  endfunction

  function automatic logic addr_is(
    input logic [`OEL_ADDR_W-1:0] a,
    input logic [`OEL_ADDR_W-1:0] b
  );
    return a == b;
  endfunction

  logic [`OEL_SRC_W-1:0]  level;
  logic [`OEL_SRC_W-1:0]  rise;
  logic [`OEL_SRC_W-1:0]  fall;

  oel_src_track #(
    .W (`OEL_SRC_W)
  ) u_track (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .src_i     (src_i),
    .level_o   (level),
    .rise_o    (rise),
    .fall_o    (fall)
  );

  oel_pkg::oel_state_t    state_ff;
  oel_pkg::oel_state_t    nxt_state;
  logic [`OEL_SRC_W-1:0]  latch_ff;
  logic [`OEL_SRC_W-1:0]  nxt_latch;
  logic [`OEL_SRC_W-1:0]  fall_en_ff;
  logic [`OEL_SRC_W-1:0]  nxt_fall_en;
  oel_pkg::oel_mode_t     mode_prev_ff;
  logic [`OEL_DATA_W-1:0] rd_data_ff;
  logic [`OEL_DATA_W-1:0] nxt_rd_data;
  logic                   rd_valid_ff;
  logic                   rd_hit_ff;
  logic                   nxt_rd_hit;

  // address decode
  wire rd_latch  = req_i.rd & addr_is(req_i.addr, `OEL_ADDR_LATCH);
  wire rd_status = req_i.rd & addr_is(req_i.addr, `OEL_ADDR_STATUS);
  wire rd_fall   = req_i.rd & (addr_is(req_i.addr, `OEL_ADDR_FALL_EN) |
                               addr_is(req_i.addr, `OEL_ADDR_FALL_SET) |
                               addr_is(req_i.addr, `OEL_ADDR_FALL_CLR));
  wire wr_fall   = req_i.wr & addr_is(req_i.addr, `OEL_ADDR_FALL_EN);
  wire wr_set    = req_i.wr & addr_is(req_i.addr, `OEL_ADDR_FALL_SET);
  wire wr_clr    = req_i.wr & addr_is(req_i.addr, `OEL_ADDR_FALL_CLR);
  wire [1:0] fall_op = wr_set ? 2'd1 : (wr_clr ? 2'd2 : 2'd0);
  wire [`OEL_SRC_W-1:0] wval = req_i.wdata[`OEL_SRC_W-1:0];

  // start-up edges from the synchroniser are not real changes
  wire running = (state_ff == oel_pkg::OEL_ST_RUN);

  // unmasked change detection
  wire [`OEL_SRC_W-1:0] edge_evt = (rise & rise_en_i) | (fall & fall_en_ff);
  wire                  loading  = (state_ff == oel_pkg::OEL_ST_LOAD);
  wire [`OEL_SRC_W-1:0] host_gate;
  wire [`OEL_SRC_W-1:0] evt;
  wire [`OEL_SRC_W-1:0] boot_set;
  wire [`OEL_SRC_W-1:0] kept;
  wire [`OEL_SRC_W-1:0] held;
  wire [`OEL_SRC_W-1:0] rd_view;

  // mode entry is a rising edge of the mode level
  wire lp_entry     = mode_i.low_power & ~mode_prev_ff.low_power;
  wire serial_entry = mode_i.serial & ~mode_prev_ff.serial;
  wire carkit_entry = mode_i.carkit & ~mode_prev_ff.carkit;
  wire mode_clear   = lp_entry | serial_entry | carkit_entry;

  genvar b;
  generate
    for (b = 0; b < `OEL_SRC_W; b++) begin : g_bit
      // only the detach source depends on the host role
      assign host_gate[b] = (b == `OEL_BIT_HOST_DETACH) ? host_mode_i : 1'b1;
      assign evt[b]       = running & edge_evt[b] & host_gate[b];
      // the detach level seen at start-up preloads its bit, in any role
      assign boot_set[b]  = (b == `OEL_BIT_HOST_DETACH) & loading & level[b];
      // an event that lands with a mode-entry clear still survives
      assign kept[b]      = ~mode_clear & latch_ff[b];
      assign held[b]      = kept[b] | evt[b] | boot_set[b];
      // a read shows the same-cycle event, and the preload, but does not latch them
      assign rd_view[b]   = latch_ff[b] | evt[b] | boot_set[b];
    end
  endgenerate

  // the read clear beats a same-cycle event, which leaves in the read data instead
  always_comb begin
    nxt_latch = rd_latch ? {`OEL_SRC_W{1'b0}} : held;
  end

  always_comb begin
    nxt_fall_en = fall_en_ff;
    if (wr_fall | wr_set | wr_clr) begin
      nxt_fall_en = alias_write(fall_en_ff, wval, fall_op);
    end
  end

  // upper bits stay zero; the latch and status registers take no write
  always_comb begin
    nxt_rd_data = `OEL_RDATA_RST;
    nxt_rd_hit  = 1'b1;
    if (rd_latch) begin
      nxt_rd_data[`OEL_SRC_W-1:0] = rd_view;
    end else if (rd_status) begin
      nxt_rd_data[`OEL_SRC_W-1:0] = level;
    end else if (rd_fall) begin
      nxt_rd_data[`OEL_SRC_W-1:0] = fall_en_ff;
    end else begin
      nxt_rd_hit = 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      oel_pkg::OEL_ST_SYNC0: nxt_state = oel_pkg::OEL_ST_SYNC1;
      oel_pkg::OEL_ST_SYNC1: nxt_state = oel_pkg::OEL_ST_LOAD;
      oel_pkg::OEL_ST_LOAD:  nxt_state = oel_pkg::OEL_ST_RUN;
      oel_pkg::OEL_ST_RUN:   nxt_state = oel_pkg::OEL_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= oel_pkg::OEL_ST_SYNC0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latch_ff <= `OEL_LATCH_RST;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fall_en_ff <= `OEL_FALL_EN_RST;
    end else begin
      fall_en_ff <= nxt_fall_en;
    end
  end

  // a mode already on at reset release reads as one entry and wipes the latch once
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_prev_ff <= '0;
    end else begin
      mode_prev_ff <= mode_i;
    end
  end

  // read data holds between reads so the link may pick it up late
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_ff  <= `OEL_RDATA_RST;
      rd_valid_ff <= 1'b0;
      rd_hit_ff   <= 1'b0;
    end else begin
      rd_data_ff  <= req_i.rd ? nxt_rd_data : rd_data_ff;
      rd_valid_ff <= req_i.rd;
      rd_hit_ff   <= req_i.rd & nxt_rd_hit;
    end
  end

  assign rd_data_o  = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign rd_hit_o   = rd_hit_ff;
  assign latch_o    = latch_ff;
  assign fall_en_o  = fall_en_ff;

endmodule

`default_nettype wire

/* sim/oel_link_model.sv */
`timescale 1ns/100ps
`default_nettype none

// link side of the register port; idle address and data flip so stale values never look valid
module oel_link_model (
  input  wire logic           clk_i,
  output var oel_pkg::oel_req_t req_o
);
  initial req_o = '0;

  // the link reads the latch only when told to, it may skip it entirely
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = {~w, w, a, d};
    @(negedge clk_i);
    req_o = {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

/* sim/oel_latch_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module oel_latch_chk (
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire oel_pkg::oel_req_t  req_i,
  input  wire oel_pkg::oel_src_t  src_i,
  input  wire oel_pkg::oel_mode_t mode_i,
  input  wire logic [7:0]         rd_data_o,
  input  wire logic               rd_valid_o,
  input  wire logic               rd_hit_o,
  input  wire logic [4:0]         latch_o,
  input  wire logic [4:0]         fall_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic rd_l = req_i.rd && req_i.addr == 6'h14;

  property p_ans; req_i.rd |=> rd_valid_o; endproperty
  a_ans: assert property (p_ans) else $error("read got no answer");
  property p_idle; !req_i.rd |=> !rd_valid_o && $stable(rd_data_o); endproperty
  a_idle: assert property (p_idle) else $error("read data moved without a read");
  property p_clr; rd_l |=> latch_o == 5'h00; endproperty
  a_clr: assert property (p_clr) else $error("latch kept after read");
  property p_keep; rd_l |=> (rd_data_o[4:0] & $past(latch_o)) == $past(latch_o); endproperty
  a_keep: assert property (p_keep) else $error("latched bit missing in read");
  property p_hi; rd_valid_o |-> rd_data_o[7:5] == 3'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits not zero");
  property p_hit;
    req_i.rd |=> rd_hit_o == ($past(req_i.addr) inside {[6'h10:6'h14]});
  endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  property p_miss; rd_valid_o && !rd_hit_o |-> rd_data_o == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read not zero");
  property p_set;
    req_i.wr && req_i.addr == 6'h11 |=>
      fall_en_o == ($past(fall_en_o) | $past(req_i.wdata[4:0]));
  endproperty
  a_set: assert property (p_set) else $error("fall enable set alias wrong");
  property p_cl;
    req_i.wr && req_i.addr == 6'h12 |=>
      fall_en_o == ($past(fall_en_o) & ~$past(req_i.wdata[4:0]));
  endproperty
  a_cl: assert property (p_cl) else $error("fall enable clear alias wrong");
  property p_mode; $stable(src_i)[*6] ##0 $rose(|mode_i) |=> latch_o == 5'h00; endproperty
  a_mode: assert property (p_mode) else $error("mode entry left latch set");
endmodule

bind oel_latch oel_latch_chk u_chk (
  .clk_i      (clk_i),
  .reset_n_i  (reset_n_i),
  .req_i      (req_i),
  .src_i      (src_i),
  .mode_i     (mode_i),
  .rd_data_o  (rd_data_o),
  .rd_valid_o (rd_valid_o),
  .rd_hit_o   (rd_hit_o),
  .latch_o    (latch_o),
  .fall_en_o  (fall_en_o)
);
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module tb_top;
  logic               clk_i = 0, reset_n_i = 0, host_mode_i = 1;
  logic [4:0]         rise_en_i = '0, fe, latch_o, fall_en_o;
  oel_pkg::oel_src_t  src_i = '0;
  oel_pkg::oel_mode_t mode_i = '0;
  oel_pkg::oel_req_t  req;
  logic [7:0]         rd_data_o;
  logic               rd_valid_o, rd_hit_o;
  logic [8:0]         expq[$];
  logic [8:0]         exp_v;
  int                 err_total = 0, total_checks = 0, seed = 88;

  always #10 clk_i = ~clk_i;
  oel_link_model lnk (.clk_i(clk_i), .req_o(req));
  oel_latch uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .src_i(src_i),
    .rise_en_i(rise_en_i), .host_mode_i(host_mode_i), .mode_i(mode_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_hit_o(rd_hit_o),
    .latch_o(latch_o), .fall_en_o(fall_en_o));

  // answers come in request order, so the oldest note belongs to this one
  always @(negedge clk_i) if (rd_valid_o === 1'b1) begin
    exp_v = expq.pop_front();
    `CHK({rd_hit_o, rd_data_o}, exp_v)
  end

  task automatic rd(input logic [5:0] a, input logic [8:0] e);
    expq.push_back(e);
    lnk.acc(1'b0, a, 8'h00);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    for (int r = 1; r >= 0; r--) begin
      @(negedge clk_i);
      reset_n_i = 0;
      src_i = {4'h0, r[0]};
      wt(16);
      reset_n_i = 1;
      wt(8);
      rd(6'h14, {8'h80, r[0]});
      rd(6'h14, 9'h100);
    end
    rd(6'h10, 9'h11F);
    rd(6'h15, 9'h000);
    for (int i = 0; i < 5; i++) begin
      fe = 5'($random(seed));
      rise_en_i = 5'($random(seed));
      lnk.acc(1'b1, 6'h10, {3'h0, ~fe});
      `CHK(fall_en_o, ~fe)
      lnk.acc(1'b1, 6'h12, 8'hFF);
      lnk.acc(1'b1, 6'h11, {3'h0, fe});
      `CHK(fall_en_o, fe)
      src_i[i] = 1'b1;
      wt(6);
      rd(6'h13, {4'h8, 5'h01 << i});
      rd(6'h14, {4'h8, rise_en_i & (5'h01 << i)});
      src_i[i] = 1'b0;
      wt(6);
      rd(6'h14, {4'h8, fe & (5'h01 << i)});
    end
    // the read is taken in the very cycle the session end rise becomes an event
    rise_en_i = 5'h1F;
    src_i[3] = 1'b1;
    wt(1);
    rd(6'h14, 9'h108);
    rd(6'h14, 9'h100);
    host_mode_i = 1'b0;
    rise_en_i = 5'h1F;
    src_i[0] = 1'b1;
    wt(6);
    rd(6'h14, 9'h100);
    lnk.acc(1'b1, 6'h11, 8'h1F);
    // toggling id each time gives a fresh event before every mode entry
    for (int m = 0; m < 3; m++) begin
      src_i[4] = ~src_i[4];
      wt(6);
      lnk.acc(1'b1, 6'h14, 8'hFF);
      `CHK(latch_o, 5'h10)
      mode_i[m] = 1'b1;
      wt(1);
      mode_i[m] = 1'b0;
      rd(6'h14, 9'h100);
    end
    wt(4);
    `CHK(expq.size(), 0)
    final_report;
  end

  initial begin
    #100000;
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire
